/* common/dma_consts.svh */
// Offsets, field positions, reset values and bus codes of the DMA master.
// Assumes inclusion by bare name from the package and the design file.
`ifndef DMA_CONSTS_SVH
`define DMA_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_CTRL       8'h00
`define OFS_COUNT      8'h04
`define OFS_ADDR       8'h08
`define OFS_START      8'h0c
`define OFS_STATUS     8'h10

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CTRL_DIR_BIT   0
`define START_BIT      0
`define ST_DONE_BIT    0
`define ST_ERR_BIT     1
`define ST_BUSY_BIT    2
`define CTRL_RST       8'h00
`define DIR_TO_FIFO    1'b1
// T3 cycles before the synchronised ready can reflect this cycle's pin
`define T3_MIN_WAIT    2'h2

// ----------------------------------------------------------------
// Bus status line codes and AXI responses
// ----------------------------------------------------------------
`define STS_PASSIVE    3'h7
`define STS_MEM_READ   3'h5
`define STS_MEM_WRITE  3'h6
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

/* common/dma_pkg.sv */
// Types shared by the DMA master and its bench.
// Assumes the constants header sits beside it on the include path.
package dma_pkg;
  `include "dma_consts.svh"

  // ----------------------------------------------------------------
  // Memory bus sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_CHECK, S_REQ, S_T1, S_T2, S_T3, S_T4, S_BACKOFF, S_WAITF
  } bus_state_t;
endpackage : dma_pkg

/* design/fifo_memory_dma_master.sv */
// DMA master moving 16-bit words between a word FIFO and main memory.
// Assumes a first-word-fall-through FIFO on the same clock, whose full
// flag already counts a write issued in the previous cycle.
`timescale 1ns/100ps
`include "dma_consts.svh"

// Functional notes
// - at most 256 words per transfer
// - 24-bit address, low on AD, high separate
// - end of transfer always interrupts processor
// - two's complement count, incremented per word
// - address increments by one per word
// - direction 1 reads memory into FIFO
// - direction 0 writes FIFO words to memory
// - check FIFO availability before requesting bus
// - hold request until arbiter acknowledges
// - one word per bus cycle, status lines
// - address on bus during T1
// - read waits for ready, FIFO by T4
// - write pre-fetches FIFO word in T4/T1
// - write data driven T2, T3, waits
// - grant lost: drop hold, wait, re-request
// - FIFO unavailable: drop hold until serviceable
// - end: interrupt and return to idle
// - read-clear status plus writable control
// - slave programming only while not transferring
module fifo_memory_dma_master
  import dma_pkg::*;
#(
  parameter int ADDR_W = 24,
  parameter int CNT_W  = 9,
  parameter int AXI_AW = 8
) (
  input  wire logic              clk_sys_in,
  input  wire logic              rst_n_in,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  input  wire logic [AXI_AW-1:0] s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  output logic                   irq_out,
  output logic                   bus_hold_request_out,
  input  wire logic              bus_hold_ack_in,
  input  wire logic              mem_ready_in,
  input  wire logic [15:0]       ad_in,
  output logic [15:0]            ad_out,
  output logic                   ad_oe_out,
  output logic [ADDR_W-17:0]     high_address_lines_out,
  output logic [2:0]             mem_status_out,
  output logic                   addr_latch_out,
  output logic                   bus_master_oe_out,
  input  wire logic              fifo_full_in,
  input  wire logic              fifo_empty_in,
  input  wire logic [15:0]       fifo_rd_data_in,
  output logic                   fifo_pop_out,
  output logic                   fifo_push_out,
  output logic [15:0]            fifo_push_data_out
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (ADDR_W < 17 || ADDR_W > 32 || CNT_W < 2 || CNT_W > 32 || AXI_AW < 5) begin : g_bad
    $error("fifo_memory_dma_master: unsupported parameter values");
  end

  bus_state_t          state_r;
  logic [7:0]          ctrl_r;
  logic [CNT_W-1:0]    count_r;
  logic [ADDR_W-1:0]   addr_r;
  logic                done_r, err_r, irq_r;
  logic                hold_r;
  logic [2:0]          ack_sync_r, rdy_sync_r;
  logic                ack_q_r, rdy_q_r;
  logic [15:0]         wdata_hold_r;
  logic                awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0]          bresp_r, rresp_r;
  logic [31:0]         rdata_r;
  logic [15:0]         ad_r;
  logic                ad_oe_r, ale_r, mst_oe_r, pop_r, push_r;
  logic [ADDR_W-17:0]  hi_r;
  logic [2:0]          sts_r;
  logic [15:0]         push_data_r;

  logic                dir, busy, fifo_ok, last, enter_t1;
  logic                wr_en, rd_en, st_rd, start_req, cnt_bad, cnt_zero;
  logic [CNT_W-1:0]    count_inc;
  logic [ADDR_W-1:0]   addr_inc, t1_addr;
  logic [1:0]          t3_cnt_r;
  logic                t3_done;
  logic [AXI_AW-1:0]   waddr;

  assign dir       = ctrl_r[`CTRL_DIR_BIT];
  assign busy      = (state_r != S_IDLE);
  assign fifo_ok   = (dir == `DIR_TO_FIFO) ? !fifo_full_in : !fifo_empty_in;
  assign count_inc = count_r + {{(CNT_W-1){1'b0}}, 1'b1};
  assign last      = (count_inc == '0);
  assign enter_t1  = ack_q_r && ((state_r == S_REQ && fifo_ok) ||
                     (state_r == S_T4 && !last && fifo_ok));
  // A nonzero count with the sign bit clear would exceed the page size
  assign cnt_bad   = !count_r[CNT_W-1] && (count_r != '0);
  assign cnt_zero  = (count_r == '0);
  // Back-to-back cycles need the address that the T4 edge is about to store
  assign addr_inc  = addr_r + {{(ADDR_W-1){1'b0}}, 1'b1};
  assign t1_addr   = (state_r == S_T4) ? addr_inc : addr_r;
  // A stale ready from the previous word must not end this data phase
  assign t3_done   = rdy_q_r && (t3_cnt_r == `T3_MIN_WAIT);

  // ----------------------------------------------------------------
  // Pin synchronisers: a change counts once stages two and three agree
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      ack_sync_r <= 3'h0;
      rdy_sync_r <= 3'h0;
      ack_q_r    <= 1'b0;
      rdy_q_r    <= 1'b0;
    end else begin
      ack_sync_r <= {ack_sync_r[1:0], bus_hold_ack_in};
      rdy_sync_r <= {rdy_sync_r[1:0], mem_ready_in};
      if (ack_sync_r[2] == ack_sync_r[1]) ack_q_r <= ack_sync_r[1];
      if (rdy_sync_r[2] == rdy_sync_r[1]) rdy_q_r <= rdy_sync_r[1];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || state_r != S_T3) t3_cnt_r <= 2'h0;
    else if (t3_cnt_r != `T3_MIN_WAIT) t3_cnt_r <= t3_cnt_r + 2'h1;
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave: address and data are taken together
  // ----------------------------------------------------------------
  assign wr_en     = awready_r && s_axi_awvalid_in && s_axi_wvalid_in;
  assign rd_en     = arready_r && s_axi_arvalid_in;
  assign waddr     = s_axi_awaddr_in;
  assign st_rd     = rd_en && (s_axi_araddr_in == AXI_AW'(`OFS_STATUS));
  assign start_req = wr_en && !busy && (waddr == AXI_AW'(`OFS_START)) &&
                     s_axi_wstrb_in[0] && s_axi_wdata_in[`START_BIT];

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) m[8*b +: 8] = new_v[8*b +: 8];
    end
    return m;
  endfunction : merge

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `RESP_OKAY;
    end else begin
      awready_r <= !awready_r && !bvalid_r && s_axi_awvalid_in && s_axi_wvalid_in;
      wready_r  <= !awready_r && !bvalid_r && s_axi_awvalid_in && s_axi_wvalid_in;
      if (wr_en) begin
        bvalid_r <= 1'b1;
        // Programming is refused from start until the sequencer is back in idle, status writes excepted
        if (busy && waddr != AXI_AW'(`OFS_STATUS)) bresp_r <= `RESP_SLVERR;
        else if (waddr == AXI_AW'(`OFS_CTRL) || waddr == AXI_AW'(`OFS_COUNT) ||
                 waddr == AXI_AW'(`OFS_ADDR) || waddr == AXI_AW'(`OFS_START) ||
                 waddr == AXI_AW'(`OFS_STATUS)) bresp_r <= `RESP_OKAY;
        else bresp_r <= `RESP_SLVERR;
      end else if (s_axi_bready_in) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= `RESP_OKAY;
      rdata_r   <= 32'h0;
    end else begin
      arready_r <= !arready_r && !rvalid_r && s_axi_arvalid_in;
      if (rd_en) begin
        rvalid_r <= 1'b1;
        rresp_r  <= `RESP_OKAY;
        case (s_axi_araddr_in)
          AXI_AW'(`OFS_CTRL):   rdata_r <= 32'(ctrl_r);
          AXI_AW'(`OFS_COUNT):  rdata_r <= 32'(count_r);
          AXI_AW'(`OFS_ADDR):   rdata_r <= 32'(addr_r);
          AXI_AW'(`OFS_START):  rdata_r <= 32'h0;
          AXI_AW'(`OFS_STATUS): rdata_r <= 32'({busy, err_r, done_r});
          default: begin
            rdata_r <= 32'h0;
            rresp_r <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready_in) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Programming registers; count and address advance per word
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      ctrl_r  <= `CTRL_RST;
      count_r <= '0;
      addr_r  <= '0;
    end else if (wr_en && !busy) begin
      if (waddr == AXI_AW'(`OFS_CTRL))
        ctrl_r <= 8'(merge(32'(ctrl_r), s_axi_wdata_in, s_axi_wstrb_in));
      if (waddr == AXI_AW'(`OFS_COUNT))
        count_r <= CNT_W'(merge(32'(count_r), s_axi_wdata_in, s_axi_wstrb_in));
      if (waddr == AXI_AW'(`OFS_ADDR))
        addr_r <= ADDR_W'(merge(32'(addr_r), s_axi_wdata_in, s_axi_wstrb_in));
    end else if (state_r == S_T4) begin
      count_r <= count_inc;
      addr_r  <= addr_r + {{(ADDR_W-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // Status flags: hardware set wins over the read-clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      done_r <= 1'b0;
      err_r  <= 1'b0;
      irq_r  <= 1'b0;
    end else begin
      if ((state_r == S_T4 && last) || (start_req && cnt_zero)) done_r <= 1'b1;
      else if (st_rd) done_r <= 1'b0;
      if (start_req && cnt_bad) err_r <= 1'b1;
      else if (st_rd) err_r <= 1'b0;
      // No mask exists: every completion reaches the processor
      irq_r <= done_r || err_r;
    end
  end

  // ----------------------------------------------------------------
  // Memory bus sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_r <= S_IDLE;
      hold_r  <= 1'b0;
    end else begin
      case (state_r)
        S_IDLE:
          if (start_req && !cnt_bad && !cnt_zero) state_r <= S_CHECK;
        S_CHECK:
          if (fifo_ok) begin
            state_r <= S_REQ;
            hold_r  <= 1'b1;
          end else begin
            state_r <= S_WAITF;
          end
        S_REQ:
          if (!fifo_ok) begin
            state_r <= S_WAITF;
            hold_r  <= 1'b0;
          end else if (ack_q_r) begin
            state_r <= S_T1;
          end
        S_T1: state_r <= S_T2;
        S_T2: state_r <= S_T3;
        S_T3: if (t3_done) state_r <= S_T4;
        S_T4:
          if (last) begin
            state_r <= S_IDLE;
            hold_r  <= 1'b0;
          end else if (!ack_q_r) begin
            state_r <= S_BACKOFF;
            hold_r  <= 1'b0;
          end else if (!fifo_ok) begin
            state_r <= S_WAITF;
            hold_r  <= 1'b0;
          end else begin
            state_r <= S_T1;
          end
        S_BACKOFF: begin
          // One idle cycle lets the higher-priority master take the bus
          state_r <= S_REQ;
          hold_r  <= 1'b1;
        end
        S_WAITF:
          if (fifo_ok) begin
            state_r <= S_REQ;
            hold_r  <= 1'b1;
          end
        default: begin
          state_r <= S_IDLE;
          hold_r  <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bus pins and FIFO strobes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      ad_r         <= 16'h0;
      ad_oe_r      <= 1'b0;
      hi_r         <= '0;
      sts_r        <= `STS_PASSIVE;
      ale_r        <= 1'b0;
      mst_oe_r     <= 1'b0;
      pop_r        <= 1'b0;
      push_r       <= 1'b0;
      push_data_r  <= 16'h0;
      wdata_hold_r <= 16'h0;
    end else begin
      pop_r  <= 1'b0;
      push_r <= 1'b0;
      if (enter_t1) begin
        ad_r     <= t1_addr[15:0];
        hi_r     <= t1_addr[ADDR_W-1:16];
        ad_oe_r  <= 1'b1;
        ale_r    <= 1'b1;
        mst_oe_r <= 1'b1;
        sts_r    <= (dir == `DIR_TO_FIFO) ? `STS_MEM_READ : `STS_MEM_WRITE;
        if (dir != `DIR_TO_FIFO) begin
          // Head word is caught now so it is ready before the data phase
          wdata_hold_r <= fifo_rd_data_in;
          pop_r        <= 1'b1;
        end
      end else begin
        case (state_r)
          S_T1: begin
            ale_r <= 1'b0;
            if (dir == `DIR_TO_FIFO) ad_oe_r <= 1'b0;
            else ad_r <= wdata_hold_r;
          end
          S_T3:
            if (t3_done) begin
              sts_r   <= `STS_PASSIVE;
              ad_oe_r <= 1'b0;
              if (dir == `DIR_TO_FIFO) begin
                push_r      <= 1'b1;
                push_data_r <= ad_in;
              end
            end
          S_T4: begin
            mst_oe_r <= 1'b0;
            ad_oe_r  <= 1'b0;
          end
          default: ;
        endcase
      end
    end
  end

  assign s_axi_awready_out      = awready_r;
  assign s_axi_wready_out       = wready_r;
  assign s_axi_bvalid_out       = bvalid_r;
  assign s_axi_bresp_out        = bresp_r;
  assign s_axi_arready_out      = arready_r;
  assign s_axi_rvalid_out       = rvalid_r;
  assign s_axi_rresp_out        = rresp_r;
  assign s_axi_rdata_out        = rdata_r;
  assign irq_out                = irq_r;
  assign bus_hold_request_out   = hold_r;
  assign ad_out                 = ad_r;
  assign ad_oe_out              = ad_oe_r;
  assign high_address_lines_out = hi_r;
  assign mem_status_out         = sts_r;
  assign addr_latch_out         = ale_r;
  assign bus_master_oe_out      = mst_oe_r;
  assign fifo_pop_out           = pop_r;
  assign fifo_push_out          = push_r;
  assign fifo_push_data_out     = push_data_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  chk_addr_in_t1: assert property (
    state_r == S_T1 |-> ad_oe_out && ad_out == addr_r[15:0] &&
      high_address_lines_out == addr_r[ADDR_W-1:16])
    else $error("address not on bus in T1");
  chk_t1_granted: assert property (
    state_r == S_T1 |-> $past(ack_q_r) && hold_r)
    else $error("bus cycle without grant");
  chk_word_advance: assert property (
    state_r == S_T4 |=> addr_r == $past(addr_r) + 1'b1 &&
      count_r == $past(count_inc))
    else $error("address or count did not advance");
  chk_rd_push: assert property (
    state_r == S_T4 && dir |-> fifo_push_out && fifo_push_data_out == $past(ad_in))
    else $error("read word not pushed in T4");
  chk_ready_wait: assert property (
    state_r == S_T3 && !rdy_q_r |=> state_r == S_T3)
    else $error("wait state skipped");
  chk_wr_data: assert property (
    (state_r == S_T2 || state_r == S_T3) && !dir |-> ad_oe_out &&
      ad_out == wdata_hold_r)
    else $error("write data not driven");
  chk_prefetch: assert property (
    state_r == S_T1 && !dir |-> fifo_pop_out)
    else $error("no prefetch in T1");
  chk_status_lines: assert property (
    state_r == S_T2 |-> mem_status_out == (dir ? `STS_MEM_READ : `STS_MEM_WRITE))
    else $error("wrong status lines");
  chk_grant_backoff: assert property (
    state_r == S_T4 && !last && !ack_q_r |=> !hold_r ##1 hold_r)
    else $error("backoff sequence wrong");
  chk_fifo_backoff: assert property (
    state_r == S_WAITF |-> !hold_r)
    else $error("hold kept while FIFO unavailable");
  chk_end_irq: assert property (
    state_r == S_T4 && last |=> state_r == S_IDLE && done_r ##1 irq_out)
    else $error("end of transfer without interrupt");

endmodule : fifo_memory_dma_master

/* testbench/mem_bus_model.sv */
// Main memory and bus arbiter seen from the DMA master's bus pins.
// Assumes the bench sets the wait count and can withdraw the grant.
`timescale 1ns/100ps
`include "dma_consts.svh"
module mem_bus_model (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic        hold_in,
  input  wire logic        block_in,
  input  wire logic [1:0]  wait_in,
  input  wire logic [15:0] ad_in,
  input  wire logic        ad_oe_in,
  input  wire logic [7:0]  high_in,
  input  wire logic [2:0]  status_in,
  input  wire logic        ale_in,
  input  wire logic        moe_in,
  output logic             ack_out,
  output logic             ready_out,
  output logic [15:0]      ad_out
);
  logic [15:0] store [logic [23:0]];
  logic [23:0] a_r;
  logic [2:0]  st_r = `STS_PASSIVE;
  logic [15:0] wd_r;
  logic [15:0] junk_r = 16'h0000;
  logic [7:0]  cnt_r = 8'h00;
  logic        oe_r = 1'b0;

  function automatic logic [15:0] rd_word(input logic [23:0] a);
    return a[15:0] ^ {a[23:16], a[23:16]} ^ 16'h3c5a;
  endfunction : rd_word

  // ----------------------------------------------------------------
  // Read data only in the data phase; a changing pattern elsewhere
  // ----------------------------------------------------------------
  assign ad_out    = (ready_out && st_r == `STS_MEM_READ) ? rd_word(a_r) : junk_r;
  assign ready_out = moe_in && !ale_in && (cnt_r >= 8'(wait_in));

  always @(posedge clk_sys_in) begin
    junk_r  <= ~ad_out;
    oe_r    <= ad_oe_in;
    cnt_r   <= ale_in ? 8'h00 : cnt_r + 8'h01;
    ack_out <= rst_n_in && hold_in && !block_in;
    if (ale_in) begin
      a_r  <= {high_in, ad_in};
      st_r <= status_in;
    end
    if (st_r == `STS_MEM_WRITE && ad_oe_in && moe_in && !ale_in) wd_r <= ad_in;
    // Memory captures each word at the end of its T4, once AD is released
    if (oe_r && !ad_oe_in && st_r == `STS_MEM_WRITE) store[a_r] = wd_r;
  end
endmodule : mem_bus_model

/* testbench/fifo_memory_dma_master_tb.sv */
// Self-checking bench for the DMA master: AXI4-Lite host, FIFO model.
// Assumes mem_bus_model stands on the memory bus side.
`timescale 1ns/100ps
`include "dma_consts.svh"
module fifo_memory_dma_master_tb;
  import dma_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, irq, hold, ack, ready, ad_oe;
  logic        ale, moe, pop, push, block = 1'b0;
  logic        f_full = 1'b0, f_empty = 1'b1;
  logic [15:0] ad_o, ad_i, f_head = 16'h0000, push_d;
  logic [7:0]  high;
  logic [2:0]  sts;
  logic [1:0]  wait_n = 2'h0;
  logic [15:0] fifo_q [$];
  int          n_fail = 0, cmp_count = 0, cyc = 0;

  fifo_memory_dma_master dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .irq_out(irq),
    .bus_hold_request_out(hold), .bus_hold_ack_in(ack), .mem_ready_in(ready),
    .ad_in(ad_i), .ad_out(ad_o), .ad_oe_out(ad_oe), .high_address_lines_out(high),
    .mem_status_out(sts), .addr_latch_out(ale), .bus_master_oe_out(moe),
    .fifo_full_in(f_full), .fifo_empty_in(f_empty), .fifo_rd_data_in(f_head),
    .fifo_pop_out(pop), .fifo_push_out(push), .fifo_push_data_out(push_d));

  mem_bus_model mem (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .hold_in(hold),
    .block_in(block), .wait_in(wait_n), .ad_in(ad_o), .ad_oe_in(ad_oe), .high_in(high),
    .status_in(sts), .ale_in(ale), .moe_in(moe), .ack_out(ack), .ready_out(ready),
    .ad_out(ad_i));

  always #5 clk_sys_in = ~clk_sys_in;

  // ----------------------------------------------------------------
  // Word FIFO, first word fall through, flags follow each edge
  // ----------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    if (push === 1'b1) fifo_q.push_back(push_d);
    if (pop === 1'b1 && fifo_q.size() > 0) void'(fifo_q.pop_front());
    f_empty <= (fifo_q.size() == 0);
    f_full  <= (fifo_q.size() >= 512);
    f_head  <= (fifo_q.size() > 0) ? fifo_q[0] : ~f_head;
    cyc     <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      stop_test();
    end
  end

  function automatic logic [15:0] exp_word(input logic [23:0] a);
    return a[15:0] ^ {a[23:16], a[23:16]} ^ 16'h3c5a;
  endfunction : exp_word

  task automatic stop_test();
    if (n_fail == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys_in);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (!(awvalid === 1'b0 || awready === 1'b1) || !(wvalid === 1'b0 || wready === 1'b1));
    while (bvalid !== 1'b1) @(posedge clk_sys_in);
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys_in);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk_sys_in); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk_sys_in);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // Programs, starts, stalls the FIFO on a write if pre < n, then checks the outcome
  task automatic xfer(input logic d, input int n, input logic [23:0] a, input int pre);
    logic [1:0]  r;
    logic [31:0] v;
    logic [15:0] w [$];
    for (int i = 0; i < n; i++) w.push_back(16'($urandom));
    @(negedge clk_sys_in);
    fifo_q.delete();
    if (!d) for (int i = 0; i < pre && i < n; i++) fifo_q.push_back(w[i]);
    wait_n <= 2'($urandom);
    axi_wr(`OFS_COUNT, 32'((10'h200 - 10'(n)) & 10'h1ff), r);
    axi_wr(`OFS_ADDR, {8'h00, a}, r);
    axi_wr(`OFS_CTRL, {31'h0, d}, r);
    axi_wr(`OFS_START, 32'h1, r);
    axi_wr(`OFS_CTRL, {31'h0, d}, r);
    chk(r, `RESP_SLVERR, "busy write");
    if (!d && pre < n) begin
      repeat (60) @(posedge clk_sys_in);
      chk(hold, 1'b0, "hold while fifo empty");
      chk(irq, 1'b0, "irq during stall");
      @(negedge clk_sys_in);
      for (int i = pre; i < n; i++) fifo_q.push_back(w[i]);
    end
    for (int i = 0; i < 6000 && irq !== 1'b1; i++) @(posedge clk_sys_in);
    chk(irq, 1'b1, "end irq");
    axi_rd(`OFS_STATUS, v, r);
    chk(v[2:0], 3'b001, "status done");
    axi_rd(`OFS_STATUS, v, r);
    chk(v[2:0], 3'b000, "status cleared");
    chk(irq, 1'b0, "irq after read");
    for (int i = 0; i < n; i++) begin
      if (d) chk(fifo_q.size() > i ? fifo_q[i] : 16'hxxxx, exp_word(24'(a + i)), "fifo");
      else chk(mem.store.exists(24'(a + i)) ? mem.store[24'(a + i)] : 16'hxxxx, w[i], "mem");
    end
    if (d) chk(fifo_q.size(), n, "word total");
    axi_rd(`OFS_ADDR, v, r);
    chk(v[23:0], 24'(a + n), "addr after");
    axi_rd(`OFS_COUNT, v, r);
    chk(v[8:0], 9'h000, "count after");
  endtask : xfer

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [1:0]  r;
    logic [31:0] v;
    void'($urandom(40298));
    repeat (4) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    axi_rd(`OFS_STATUS, v, r);
    chk(v, 32'h0, "status at reset");
    axi_rd(8'h14, v, r);
    chk(r, `RESP_SLVERR, "unmapped read");
    axi_wr(8'h18, 32'h1, r);
    chk(r, `RESP_SLVERR, "unmapped write");
    xfer(1'b1, 3, 24'hfffffe, 0);
    xfer(1'b0, 4, 24'h00fffe, 4);
    for (int k = 0; k < 4; k++) xfer(1'($urandom), 1 + $urandom % 16, 24'($urandom), 16);
    xfer(1'b0, 6, 24'h123456, 2);
    fork
      xfer(1'b1, 8, 24'h0abcde, 0);
      begin
        repeat (30) @(posedge clk_sys_in);
        block <= 1'b1;
        repeat (12) @(posedge clk_sys_in);
        block <= 1'b0;
      end
    join
    xfer(1'b1, 256, 24'h3fff00, 0);
    axi_wr(`OFS_COUNT, 32'h5, r);
    axi_wr(`OFS_START, 32'h1, r);
    repeat (4) @(posedge clk_sys_in);
    chk(irq, 1'b1, "error irq");
    axi_rd(`OFS_STATUS, v, r);
    chk(v[1:0], 2'b10, "error flag");
    chk(hold, 1'b0, "no bus on error");
    stop_test();
  end
endmodule : fifo_memory_dma_master_tb
